// [pkg/qpsc_pkg.sv]
// ----------------------------------------------------------------------------
// Shared constants and types for the quad potentiometer serial control
// ----------------------------------------------------------------------------
package qpsc_pkg;

    // Array geometry
    localparam int NUM_POTS = 4;
    localparam int STORE_DEPTH = 4;
    localparam int DATA_W = 8;

    // Operation codes, upper nibble of the instruction byte
    localparam logic [3:0] OP_READ_WIPER = 4'h1;
    localparam logic [3:0] OP_WRITE_WIPER = 4'h2;
    localparam logic [3:0] OP_READ_STORE = 4'h3;
    localparam logic [3:0] OP_WRITE_STORE = 4'h4;
    localparam logic [3:0] OP_XFER = 4'h5;
    localparam logic [3:0] OP_INC_DEC = 4'h6;

    // Instruction byte fields
    localparam int INSTR_OP_MSB = 7;
    localparam int INSTR_OP_LSB = 4;
    localparam int INSTR_DEV_MSB = 3;
    localparam int INSTR_DEV_LSB = 2;
    localparam int INSTR_POT_MSB = 1;
    localparam int INSTR_POT_LSB = 0;

    // Second byte fields: direction flag, step count, stored register index
    localparam int DIR_BIT = 7;
    localparam int STEP_MSB = 6;
    localparam int IDX_MSB = 1;

    // Timing
    localparam int CLK_FREQ_MHZ = 125;
    localparam int NV_WRITE_TIME_NS = 5000;
    localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int BUSY_W = 10;
    localparam logic [1:0] INIT_CYCLES = 2'h3;

    // Reset values
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam int CROSS_W = 5;
    localparam logic [CROSS_W-1:0] CROSS_RESET = 5'h18;

    // Link phase, Gray coded along the normal path
    typedef enum logic [1:0] {
        PH_INSTR = 2'b00,
        PH_SECOND = 2'b01,
        PH_THIRD = 2'b11,
        PH_DONE = 2'b10
    } qpsc_phase_t;

    // Completed command handed from the link to the core
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] pot;
        logic [1:0] idx;
        logic [7:0] data;
    } qpsc_cmd_t;

    // Levels crossing into the system clock domain
    typedef struct packed {
        logic cs_b;
        logic wp_b;
        logic done_tgl;
        logic [1:0] strap;
    } qpsc_cross_t;

    typedef logic [NUM_POTS-1:0][DATA_W-1:0] qpsc_wipers_t;

endpackage

// [hdl/qpsc_sync.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Two flip-flop level synchroniser
// ----------------------------------------------------------------------------
module qpsc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // qpsc_sync

// [hdl/qpsc_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - Serial input bits are sampled on rising serial clock edges.
// - Read data changes on falling serial clock edges.
// - Two address straps give the device one of four addresses.
// - Only an instruction whose address field matches the straps is obeyed.
// - Chip select high floats the output; a running store write still ends.
// - Internal write starts only on chip select rising after a full write.
// - Write protect low blocks stored writes but not wiper changes.
// - Write protect falling during select cancels the pending stored write.
// - A stored write already begun ignores write protect.
// - While paused output floats, input is ignored, state is kept.
// - An 8-bit instruction register holds the first byte of a frame.
// - The first byte carries one of six operation codes.
// - Each pot has one wiper register and four stored registers.
// - At power-up each wiper loads its first stored register.
// - Each wiper connects the single tap named by its wiper register.
// - Commands move settings between wiper and store, and step the wiper.
module qpsc_top (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    input wire logic sck,
    input wire logic cs_b,
    input wire logic si,
    input wire logic hold_b,
    output logic so_out,
    output logic so_oe,
    // Straps and protection
    input wire logic dev_addr_bit0,
    input wire logic dev_addr_bit1,
    input wire logic wp_b,
    // Potentiometer taps and status
    output qpsc_pkg::qpsc_wipers_t wiper_tap,
    output logic nv_busy
);
    import qpsc_pkg::*;

    // ------------------------------------------------------------------------
    // Storage shared by both domains
    // ------------------------------------------------------------------------
    // Nonvolatile store and wiper registers live in the system domain; the
    // link reads them only mid-frame, when the core never changes them.
    logic [7:0] stored_setting_reg [NUM_POTS][STORE_DEPTH];
    qpsc_wipers_t wiper_setting_reg;
    logic [1:0] strap_reg;

    // ------------------------------------------------------------------------
    // Link domain: shifter and phase
    // ------------------------------------------------------------------------
    logic frame_rst_b;
    logic [2:0] bit_cnt_reg;
    qpsc_phase_t phase_reg;
    qpsc_phase_t phase_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] instr_reg;
    logic [7:0] second_reg;
    logic byte_end;
    logic [3:0] op_in;
    logic [1:0] dev_in;
    logic addr_match;
    logic op_valid_in;
    logic [3:0] op_cur;
    logic [1:0] pot_cur;
    logic three_byte;

    // Frame restarts whenever chip select is high
    assign frame_rst_b = rst_b & ~cs_b;
    assign shift_next = {shift_reg[6:0], si};
    assign byte_end = (bit_cnt_reg == 3'h7);

    // Instruction decode of the byte now completing
    assign op_in = shift_next[INSTR_OP_MSB:INSTR_OP_LSB];
    assign dev_in = shift_next[INSTR_DEV_MSB:INSTR_DEV_LSB];
    assign addr_match = (dev_in == strap_reg);
    assign op_valid_in = (op_in >= OP_READ_WIPER) && (op_in <= OP_INC_DEC);
    assign op_cur = instr_reg[INSTR_OP_MSB:INSTR_OP_LSB];
    assign pot_cur = instr_reg[INSTR_POT_MSB:INSTR_POT_LSB];
    assign three_byte = (op_cur == OP_READ_STORE) || (op_cur == OP_WRITE_STORE);

    // Phase sequencing; a mismatched or unknown instruction idles the frame
    always_comb
    begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_INSTR:
            begin
                if (byte_end)
                    phase_next = (addr_match && op_valid_in) ? PH_SECOND : PH_DONE;
            end
            PH_SECOND:
            begin
                if (byte_end)
                    phase_next = three_byte ? PH_THIRD : PH_DONE;
            end
            PH_THIRD:
            begin
                if (byte_end)
                    phase_next = PH_DONE;
            end
            PH_DONE:
            begin
                phase_next = PH_DONE;
            end
        endcase
    end

    // Shifter; pause low freezes it, which is safe because pause only
    // moves while the clock is low, so it is stable at each rising edge
    always_ff @(posedge sck or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            bit_cnt_reg <= 3'h0;
            phase_reg <= PH_INSTR;
            shift_reg <= 8'h00;
            instr_reg <= 8'h00;
            second_reg <= 8'h00;
        end
        else if (hold_b)
        begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            phase_reg <= phase_next;
            shift_reg <= shift_next;
            if (phase_reg == PH_INSTR && byte_end)
                instr_reg <= shift_next;
            if (phase_reg == PH_SECOND && byte_end)
                second_reg <= shift_next;
        end
    end

    // ------------------------------------------------------------------------
    // Link domain: command hand-off
    // ------------------------------------------------------------------------
    logic commit;
    qpsc_cmd_t cmd_next;
    qpsc_cmd_t cmd_reg;
    logic done_tgl_reg;

    // Only a write frame that reached its last bit is handed over
    assign commit = hold_b && byte_end &&
        ((phase_reg == PH_SECOND && !three_byte && op_cur != OP_READ_WIPER) ||
         (phase_reg == PH_THIRD && op_cur == OP_WRITE_STORE));
    assign cmd_next.op = op_cur;
    assign cmd_next.pot = pot_cur;
    assign cmd_next.idx = (phase_reg == PH_THIRD) ? second_reg[IDX_MSB:0] :
        shift_next[IDX_MSB:0];
    assign cmd_next.data = shift_next;

    // Command word is held until the next full write frame; the toggle tells the
    // core that a new word is waiting
    always_ff @(posedge sck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_reg <= '0;
            done_tgl_reg <= 1'b0;
        end
        else if (commit)
        begin
            cmd_reg <= cmd_next;
            done_tgl_reg <= ~done_tgl_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Link domain: read output
    // ------------------------------------------------------------------------
    logic rd_active;
    logic [7:0] rd_byte;
    logic so_reg;

    assign rd_active = (phase_reg == PH_SECOND && op_cur == OP_READ_WIPER) ||
        (phase_reg == PH_THIRD && op_cur == OP_READ_STORE);
    assign rd_byte = (phase_reg == PH_THIRD) ?
        stored_setting_reg[pot_cur][second_reg[IDX_MSB:0]] :
        wiper_setting_reg[pot_cur];

    // Output bit moves on the falling edge, MSB first
    always_ff @(negedge sck or negedge rst_b)
    begin
        if (!rst_b)
            so_reg <= 1'b0;
        else if (hold_b)
            so_reg <= rd_active ? rd_byte[~bit_cnt_reg] : 1'b0;
    end

    // Drive only while selected, not paused and inside a read byte
    assign so_out = so_reg;
    assign so_oe = ~cs_b & hold_b & rd_active;

    // ------------------------------------------------------------------------
    // System domain: crossing and edges
    // ------------------------------------------------------------------------
    qpsc_cross_t cross_in;
    qpsc_cross_t cross_s;
    logic cs_d_reg;
    logic wp_d_reg;
    logic exec_tgl_reg;
    logic abort_reg;
    logic abort_next;
    logic [1:0] init_cnt_reg;
    logic [BUSY_W-1:0] busy_cnt_reg;
    logic cs_rise;
    logic cs_fall;
    logic wp_fall;
    logic init_done;
    logic new_cmd;

    assign cross_in.cs_b = cs_b;
    assign cross_in.wp_b = wp_b;
    assign cross_in.done_tgl = done_tgl_reg;
    assign cross_in.strap = {dev_addr_bit1, dev_addr_bit0};

    qpsc_sync #(
        .WIDTH(CROSS_W),
        .RESET_VAL(CROSS_RESET)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(cross_in),
        .q(cross_s)
    );

    // Edge detection on synchronised levels only
    assign cs_rise = cross_s.cs_b & ~cs_d_reg;
    assign cs_fall = ~cross_s.cs_b & cs_d_reg;
    assign wp_fall = ~cross_s.wp_b & wp_d_reg;
    assign init_done = (init_cnt_reg == 2'h0);
    // The link clock has stopped by the time chip select is seen high, so
    // the command word is stable when sampled here
    assign new_cmd = cs_rise & init_done & (cross_s.done_tgl != exec_tgl_reg);
    // Cancel set wins over the clear at a new frame start
    assign abort_next = (wp_fall & ~cross_s.cs_b) | (abort_reg & ~cs_fall);

    // Edge history, cancel flag and command bookkeeping
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cs_d_reg <= 1'b1;
            wp_d_reg <= 1'b1;
            exec_tgl_reg <= 1'b0;
            abort_reg <= 1'b0;
            init_cnt_reg <= INIT_CYCLES;
        end
        else
        begin
            cs_d_reg <= cross_s.cs_b;
            wp_d_reg <= cross_s.wp_b;
            abort_reg <= abort_next;
            if (cs_rise)
                exec_tgl_reg <= cross_s.done_tgl;
            if (!init_done)
                init_cnt_reg <= init_cnt_reg - 2'h1;
        end
    end

    // ------------------------------------------------------------------------
    // System domain: command execution
    // ------------------------------------------------------------------------
    logic nv_ok;
    logic dir;
    logic [6:0] steps;
    logic [7:0] cur_wiper;
    logic [8:0] up_sum;
    logic [7:0] stepped;
    logic do_ww;
    logic do_ws;
    logic do_recall;
    logic do_save;
    logic do_incdec;
    logic store_we;
    logic [7:0] store_wdata;
    logic wiper_we;
    logic [7:0] wiper_wdata;

    // Stored writes need protect high, no cancel and no write in flight
    assign nv_ok = cross_s.wp_b & ~abort_reg & ~nv_busy;
    assign dir = cmd_reg.data[DIR_BIT];
    assign steps = cmd_reg.data[STEP_MSB:0];
    assign cur_wiper = wiper_setting_reg[cmd_reg.pot];

    // Operation decode
    assign do_ww = new_cmd && cmd_reg.op == OP_WRITE_WIPER;
    assign do_ws = new_cmd && cmd_reg.op == OP_WRITE_STORE && nv_ok;
    assign do_recall = new_cmd && cmd_reg.op == OP_XFER && !dir;
    assign do_save = new_cmd && cmd_reg.op == OP_XFER && dir && nv_ok;
    assign do_incdec = new_cmd && cmd_reg.op == OP_INC_DEC;

    // Stepping saturates at both ends of the array
    assign up_sum = {1'b0, cur_wiper} + {2'b00, steps};
    assign stepped = dir ? (up_sum[8] ? 8'hff : up_sum[7:0]) :
        ((cur_wiper < {1'b0, steps}) ? 8'h00 : cur_wiper - {1'b0, steps});

    // Write data selection
    assign store_we = do_ws | do_save;
    assign store_wdata = do_save ? cur_wiper : cmd_reg.data;
    assign wiper_we = do_ww | do_recall | do_incdec;
    assign wiper_wdata = do_ww ? cmd_reg.data :
        (do_recall ? stored_setting_reg[cmd_reg.pot][cmd_reg.idx] : stepped);

    // Store commits at the start of the write cycle, so its contents stay
    // steady for link reads while the busy time runs out
    always_ff @(posedge clk)
    begin
        if (store_we)
            stored_setting_reg[cmd_reg.pot][cmd_reg.idx] <= store_wdata;
    end

    // Busy time runs to the end whatever chip select or protect do
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            busy_cnt_reg <= '0;
        else if (store_we)
            busy_cnt_reg <= BUSY_W'(NV_WRITE_CYCLES);
        else if (nv_busy)
            busy_cnt_reg <= busy_cnt_reg - BUSY_W'(1);
    end
    assign nv_busy = (busy_cnt_reg != '0);

    // Wipers; the last init cycle recalls the first stored setting and
    // captures the straps once their synchroniser has settled
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wiper_setting_reg <= {NUM_POTS{WIPER_RESET}};
            strap_reg <= 2'h0;
        end
        else if (init_cnt_reg == 2'h1)
        begin
            for (int p = 0; p < NUM_POTS; p++)
                wiper_setting_reg[p] <= stored_setting_reg[p][0];
            strap_reg <= cross_s.strap;
        end
        else if (wiper_we)
            wiper_setting_reg[cmd_reg.pot] <= wiper_wdata;
    end

    // One tap index per pot, straight from its wiper register
    assign wiper_tap = wiper_setting_reg;

endmodule // qpsc_top

// [verif/qpsc_checker_assertions.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port level checks of the serial control block
// ----------------------------------------------------------------------------
module qpsc_checker (
    // System
    input wire logic clk,
    input wire logic rst_b,
    // Serial link
    input wire logic sck,
    input wire logic cs_b,
    input wire logic hold_b,
    input wire logic so_out,
    input wire logic so_oe,
    // Protection and results
    input wire logic wp_b,
    input wire qpsc_pkg::qpsc_wipers_t wiper_tap,
    input wire logic nv_busy
);
    import qpsc_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Length of the running store write; a counter since the cycle is far too long to unroll
    logic [10:0] busy_cnt_reg;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            busy_cnt_reg <= 11'h000;
        else if (nv_busy)
            busy_cnt_reg <= busy_cnt_reg + 11'h001;
        else
            busy_cnt_reg <= 11'h000;
    end

    // Protect fell inside the open frame; only the next frame start clears it,
    // so a store write launched at that frame's end is caught
    logic wp_cut_reg;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wp_cut_reg <= 1'b0;
        else if (!cs_b && $fell(wp_b))
            wp_cut_reg <= 1'b1;
        else if ($fell(cs_b))
            wp_cut_reg <= 1'b0;
    end

    property p_oe_sel; so_oe |-> !cs_b; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("so driven while deselected");
    property p_hold; !hold_b |-> !so_oe; endproperty
    a_hold: assert property (p_hold) else $error("so driven while paused");
    property p_so_edge; so_oe && $past(so_oe) && $changed(so_out) |-> $fell(sck); endproperty
    a_so_edge: assert property (p_so_edge) else $error("so moved off falling sck");
    property p_busy_len; $fell(nv_busy) |-> busy_cnt_reg == 11'(NV_WRITE_CYCLES); endproperty
    a_busy_len: assert property (p_busy_len) else $error("store cycle length wrong");
    property p_busy_cs; $rose(nv_busy) |-> cs_b && $past(cs_b, 2); endproperty
    a_busy_cs: assert property (p_busy_cs) else $error("store began while selected");
    property p_wp_block; (!wp_b)[*6] |-> !$rose(nv_busy); endproperty
    a_wp_block: assert property (p_wp_block) else $error("store write under protect");
    property p_wp_abort; wp_cut_reg |-> !$rose(nv_busy); endproperty
    a_wp_abort: assert property (p_wp_abort) else $error("aborted write started");
    property p_wiper_cs; $changed(wiper_tap) |-> cs_b && $past(cs_b, 2); endproperty
    a_wiper_cs: assert property (p_wiper_cs) else $error("wiper moved mid frame");

    // Main scenarios reached
    c_read: cover property ($rose(so_oe));
    c_store: cover property ($rose(nv_busy));
    c_pause: cover property (!hold_b && !cs_b);
    c_wiper: cover property ($changed(wiper_tap));
endmodule // qpsc_checker

bind qpsc_top qpsc_checker chk_u (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
    .hold_b(hold_b), .so_out(so_out), .so_oe(so_oe), .wp_b(wp_b), .wiper_tap(wiper_tap),
    .nv_busy(nv_busy));

// [verif/qpsc_master.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Serial bus master model, 32 ns link clock that stands still outside frames
// ----------------------------------------------------------------------------
module qpsc_master (
    // Serial link
    output logic sck,
    output logic cs_b,
    output logic si,
    output logic hold_b,
    input wire logic so_out,
    input wire logic so_oe
);
    // Idle bus, pause unused
    initial
    begin
        sck = 1'b0;
        cs_b = 1'b1;
        si = 1'b0;
        hold_b = 1'b1;
    end

    // One frame of n bits, MSB first from tx[23]; optional pause before bit pause_at
    task automatic frame(input logic [23:0] tx, input int n, input int pause_at,
                         output logic [7:0] rx);
        logic b;
        b = 1'b0;
        rx = 8'h00;
        cs_b = 1'b0;
        #16;
        for (int i = 0; i < n; i++)
        begin
            if (i == pause_at)
            begin
                // Pause edges sit mid-way in the low phase, clear of any clock edge
                #8 hold_b = 1'b0;
                repeat (2)
                begin
                    si = ~si;
                    #16 sck = 1'b1;
                    #16 sck = 1'b0;
                end
                #8 hold_b = 1'b1;
                #8;
            end
            si = tx[23 - i];
            #16;
            // Sample before the rise; a floating line reads as the inverse of the last bit
            b = so_oe ? so_out : ~b;
            rx = {rx[6:0], b};
            sck = 1'b1;
            #16 sck = 1'b0;
        end
        #16 cs_b = 1'b1;
        si = ~si;
        #64;
    endtask
endmodule // qpsc_master

// [verif/testbench.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Self-checking bench of the serial control block
// ----------------------------------------------------------------------------
module testbench;
    import qpsc_pkg::*;
    localparam logic [1:0] DEV = 2'h2;
    logic clk, rst_b, wp_b, dev_addr_bit0, dev_addr_bit1;
    logic sck, cs_b, si, hold_b, so_out, so_oe, nv_busy;
    qpsc_wipers_t wiper_tap;
    int err_total, tests_run;
    logic [7:0] exp_w [4];
    logic [7:0] st_val [4];
    logic [7:0] rd;

    qpsc_top dut_u (.clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
        .hold_b(hold_b), .so_out(so_out), .so_oe(so_oe), .dev_addr_bit0(dev_addr_bit0),
        .dev_addr_bit1(dev_addr_bit1), .wp_b(wp_b), .wiper_tap(wiper_tap), .nv_busy(nv_busy));
    qpsc_master master_u (.sck(sck), .cs_b(cs_b), .si(si), .hold_b(hold_b),
        .so_out(so_out), .so_oe(so_oe));

    // System clock, 8 ns
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmd(input logic [3:0] op, input logic [1:0] d, p,
                       input logic [7:0] b1, b2, input int n, pa);
        // Frames start just after a system edge, so no link edge meets a clk edge
        @(posedge clk) #1;
        master_u.frame({op, d, p, b1, b2}, n, pa, rd);
    endtask

    task automatic pulse_reset(input int n);
        @(posedge clk) #1 rst_b = 1'b0;
        repeat (n) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (nv_busy !== 1'b0 && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        check("store cycle end", {7'h00, nv_busy}, 8'h00);
        if (k == 2000)
            stop_test();
    endtask

    task automatic check_wipers();
        for (int p = 0; p < 4; p++)
            check("wiper_tap", wiper_tap[p], exp_w[p]);
    endtask

    // Store each first register, then recall at reset
    task automatic t_recall();
        for (int p = 0; p < 4; p++)
        begin
            st_val[p] = 8'h3c + 8'(p * 17);
            cmd(OP_WRITE_STORE, DEV, 2'(p), 8'h00, st_val[p], 24, 99);
            check("busy", {7'h00, nv_busy}, 8'h01);
            wait_idle();
            exp_w[p] = st_val[p];
        end
        pulse_reset(4);
        check_wipers();
    endtask

    // Wiper write with a pause, then read back with a pause
    task automatic t_wiper_rw();
        cmd(OP_WRITE_WIPER, DEV, 2'h2, 8'ha5, 8'h00, 16, 11);
        exp_w[2] = 8'ha5;
        check_wipers();
        cmd(OP_READ_WIPER, DEV, 2'h2, 8'h00, 8'h00, 16, 12);
        check("read wiper", rd, 8'ha5);
    endtask

    // Only the strapped address is obeyed; short frames change nothing
    task automatic t_addr_short();
        for (int d = 0; d < 4; d++)
        begin
            cmd(OP_WRITE_WIPER, 2'(d), 2'h1, 8'h40 + 8'(d), 8'h00, 16, 99);
            if (d == DEV)
                exp_w[1] = 8'h40 + 8'(d);
        end
        cmd(OP_WRITE_WIPER, DEV, 2'h1, 8'hff, 8'h00, 15, 99);
        cmd(4'h7, DEV, 2'h1, 8'hee, 8'h00, 16, 99);
        check_wipers();
        cmd(OP_WRITE_STORE, DEV, 2'h1, 8'h00, 8'h12, 23, 99);
        check("short store", {7'h00, nv_busy}, 8'h00);
    endtask

    // Write protect: begun cycle kept, abort mid frame, hold blocks store only
    task automatic t_protect();
        cmd(OP_WRITE_STORE, DEV, 2'h0, 8'h01, 8'h77, 24, 99);
        @(posedge clk) #1 wp_b = 1'b0;
        wait_idle();
        #1 wp_b = 1'b1;
        cmd(OP_READ_STORE, DEV, 2'h0, 8'h01, 8'h00, 24, 99);
        check("store kept", rd, 8'h77);
        fork
            cmd(OP_WRITE_STORE, DEV, 2'h0, 8'h01, 8'h99, 24, 99);
            begin
                #200 @(posedge clk) #1 wp_b = 1'b0;
                repeat (10) @(posedge clk);
                #1 wp_b = 1'b1;
            end
        join
        check("abort busy", {7'h00, nv_busy}, 8'h00);
        @(posedge clk) #1 wp_b = 1'b0;
        repeat (4) @(posedge clk);
        cmd(OP_WRITE_STORE, DEV, 2'h0, 8'h01, 8'h55, 24, 99);
        check("protect busy", {7'h00, nv_busy}, 8'h00);
        cmd(OP_WRITE_WIPER, DEV, 2'h0, 8'h66, 8'h00, 16, 99);
        exp_w[0] = 8'h66;
        check_wipers();
        @(posedge clk) #1 wp_b = 1'b1;
        repeat (4) @(posedge clk);
        cmd(OP_READ_STORE, DEV, 2'h0, 8'h01, 8'h00, 24, 99);
        check("store unchanged", rd, 8'h77);
    endtask

    // Save, recall and saturating steps
    task automatic t_xfer_step();
        cmd(OP_XFER, DEV, 2'h0, 8'h82, 8'h00, 16, 99);
        wait_idle();
        cmd(OP_READ_STORE, DEV, 2'h0, 8'h02, 8'h00, 24, 99);
        check("saved", rd, 8'h66);
        cmd(OP_WRITE_WIPER, DEV, 2'h3, 8'h01, 8'h00, 16, 99);
        cmd(OP_XFER, DEV, 2'h3, 8'h00, 8'h00, 16, 99);
        cmd(OP_INC_DEC, DEV, 2'h3, 8'h83, 8'h00, 16, 99);
        cmd(OP_INC_DEC, DEV, 2'h2, 8'hff, 8'h00, 16, 99);
        cmd(OP_INC_DEC, DEV, 2'h1, 8'h50, 8'h00, 16, 99);
        exp_w[3] = st_val[3] + 8'h03;
        exp_w[2] = 8'hff;
        exp_w[1] = 8'h00;
        check_wipers();
    endtask

    // Main sequence
    initial
    begin
        err_total = 0;
        tests_run = 0;
        rst_b = 1'b0;
        wp_b = 1'b1;
        dev_addr_bit0 = DEV[0];
        dev_addr_bit1 = DEV[1];
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge clk);
        t_recall();
        t_wiper_rw();
        t_addr_short();
        t_protect();
        t_xfer_step();
        stop_test();
    end
endmodule // testbench
